// *** shared/sdd_pkg.sv ***
// What this block does
// - two axes, each with its own identical set of setting decodes
// - 16-position current selector gives 0.6 A at 0 up to 2.5 A at F
// - step switches give 200, 400, 500 or 1000 steps, 1000 by default
// - fine switch differing from micro-step input multiplies resolution by ten
// - first axis fine switch is position 1, second axis is position 3
// - reduction switch OFF turns standstill current reduction on
// - function switch OFF means enable input, ON means pulse gate
// - ready and readiness output come on when running without fault and, in enable mode, enabled
// - overvoltage sets a fault flag and lights the overvoltage indicator
// - each pulse rising edge moves one step in the commanded direction while ready, unless gated
// - in gate mode pulses are ignored while the gate input is energized
// - in enable mode ready follows about 100 ms after enable is energized
// - enable dropped opens readiness, resets phase ring and clears the fault
package sdd_pkg;
   localparam int CLK_PERIOD_NS = 4;
   localparam int READY_DELAY_MS = 100;
   localparam int READY_DELAY_CYC = READY_DELAY_MS * 1000000 / CLK_PERIOD_NS;
   localparam int FINE_POS_A1 = 0;
   localparam int FINE_POS_A2 = 2;
   localparam logic [2:0] PHASE_LAST = 3'h5;
   localparam logic [13:0] RES_200 = 14'h00c8;
   localparam logic [13:0] RES_400 = 14'h0190;
   localparam logic [13:0] RES_500 = 14'h01f4;
   localparam logic [13:0] RES_1000 = 14'h03e8;
   // register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam logic [7:0] SET_A1_OFS = 8'h08;
   localparam logic [7:0] SET_A2_OFS = 8'h0c;
   localparam logic [7:0] INT_STATUS_OFS = 8'h10;
   localparam logic [7:0] INT_MASK_OFS = 8'h14;
   localparam logic [1:0] CTRL_RESET = 2'h3;
   localparam logic [3:0] INT_MASK_RESET = 4'h0;
   localparam int SET_RES_POS = 12;
   localparam int SET_DA_POS = 4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic pulse;
      logic dir;
      logic gate_en;
      logic micro_in;
      logic ov_detect;
      logic [3:0] phase_current_selector;
      logic [1:0] step_sw;
      logic current_reduction_switch;
      logic inhibit_or_enable_select;
   } sdd_axis_in_t;

   typedef struct packed {
      logic [3:0] cur_code;
      logic [4:0] cur_deciamp;
      logic [13:0] res;
      logic ired_on;
      logic gate_mode;
      logic step;
      logic dir;
      logic [2:0] phase;
      logic ring_rst;
      logic ready_led;
      logic relay_closed;
      logic ov_led;
      logic fault;
   } sdd_axis_out_t;
endpackage

// *** verilog/sdd_drive_setup.sv ***
`timescale 1ns/10ps
module sdd_drive_setup
#(
   parameter int unsigned READY_CYCLES = sdd_pkg::READY_DELAY_CYC
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire sdd_pkg::sdd_axis_in_t [1:0] axis_in,
   input wire logic [3:0] micro_dip,
   output sdd_pkg::sdd_axis_out_t [1:0] axis_out,
   output logic irq,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import sdd_pkg::*;

   function automatic logic [4:0] cur_fn(input logic [3:0] sel);
      logic [4:0] t;
      t = 5'h00;
      case (sel)
         4'h0: t = 5'd6;
         4'h1: t = 5'd8;
         4'h2: t = 5'd9;
         4'h3: t = 5'd10;
         4'h4: t = 5'd11;
         4'h5: t = 5'd13;
         4'h6: t = 5'd14;
         4'h7: t = 5'd15;
         4'h8: t = 5'd16;
         4'h9: t = 5'd18;
         4'ha: t = 5'd19;
         4'hb: t = 5'd20;
         4'hc: t = 5'd21;
         4'hd: t = 5'd23;
         4'he: t = 5'd24;
         default: t = 5'd25;
      endcase
      return t;
   endfunction

   // switch bit high means ON
   function automatic logic [13:0] res_fn(input logic [1:0] sw, input logic mult);
      logic [13:0] b;
      b = RES_1000;
      case (sw)
         2'b01: b = RES_200;
         2'b11: b = RES_400;
         2'b10: b = RES_500;
         default: b = RES_1000;
      endcase
      return mult ? 14'((b << 3) + (b << 1)) : b;
   endfunction

   // three-stage pin synchroniser, a change counts once stages two and three agree
   localparam int SW = $bits(sdd_axis_in_t) * 2 + 4;
   logic [SW-1:0] s1_reg, s2_reg, s3_reg, filt_reg;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         filt_reg <= '0;
      end
      else
      begin
         s1_reg <= {micro_dip, axis_in};
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         // hold while stages two and three disagree, follow them once they match
         filt_reg <= (s2_reg & s3_reg) | (filt_reg & (s2_reg ^ s3_reg));
      end
   end

   sdd_axis_in_t [1:0] pin;
   logic [3:0] dip;
   assign pin = filt_reg[SW-5:0];
   assign dip = filt_reg[SW-1:SW-4];

   logic [1:0] ctrl_en_reg;
   logic [3:0] int_status_reg, int_status_next, int_mask_reg, int_mask_next;
   logic [1:0] ov_evt, rdy_evt;
   logic [1:0] fine_sw;
   assign fine_sw = {dip[FINE_POS_A2], dip[FINE_POS_A1]};

   genvar g;
   for (g = 0; g < 2; g++)
   begin : axis_g
      // each axis runs its own copy of every decode
      sdd_axis_out_t o_reg;
      logic pulse_d_reg, enabled, clear_fault, go_ok, edge_ok;
      logic [31:0] en_cnt_reg;
      assign enabled = pin[g].gate_en;
      assign clear_fault = !pin[g].inhibit_or_enable_select && !enabled;
      // an arriving overvoltage drops ready in the same cycle the fault latches
      assign go_ok = ctrl_en_reg[g] && !o_reg.fault && !pin[g].ov_detect;
      assign edge_ok = pin[g].pulse && !pulse_d_reg;

      always_ff @(posedge aclk)
      begin
         if (!aresetn)
            en_cnt_reg <= '0;
         else if (pin[g].inhibit_or_enable_select || !enabled)
            en_cnt_reg <= '0;
         else if (en_cnt_reg < READY_CYCLES)
            en_cnt_reg <= en_cnt_reg + 32'd1;
      end

      always_ff @(posedge aclk)
      begin
         if (!aresetn)
         begin
            o_reg <= '0;
            pulse_d_reg <= 1'b0;
         end
         else
         begin
            pulse_d_reg <= pin[g].pulse;
            o_reg.cur_code <= pin[g].phase_current_selector;
            o_reg.cur_deciamp <= cur_fn(pin[g].phase_current_selector);
            o_reg.res <= res_fn(pin[g].step_sw, fine_sw[g] ^ pin[g].micro_in);
            o_reg.ired_on <= !pin[g].current_reduction_switch;
            o_reg.gate_mode <= pin[g].inhibit_or_enable_select;
            o_reg.dir <= pin[g].dir;
            // set wins over the clear from a dropped enable
            o_reg.fault <= pin[g].ov_detect || (o_reg.fault && !clear_fault);
            o_reg.ov_led <= pin[g].ov_detect || o_reg.fault || clear_fault;
            o_reg.ring_rst <= clear_fault;
            if (pin[g].inhibit_or_enable_select)
               o_reg.ready_led <= go_ok;
            else
               o_reg.ready_led <= go_ok && enabled && en_cnt_reg >= READY_CYCLES;
            o_reg.relay_closed <= o_reg.ready_led;
            // a step needs a ready drive; gate mode also blocks on energized gate
            o_reg.step <= edge_ok && o_reg.ready_led &&
               !(pin[g].inhibit_or_enable_select && enabled);
            if (clear_fault)
               o_reg.phase <= 3'h0;
            else if (o_reg.step)
            begin
               if (!o_reg.dir)
                  o_reg.phase <= (o_reg.phase == PHASE_LAST) ? 3'h0 : o_reg.phase + 3'h1;
               else
                  o_reg.phase <= (o_reg.phase == 3'h0) ? PHASE_LAST : o_reg.phase - 3'h1;
            end
         end
      end
      assign axis_out[g] = o_reg;
      assign ov_evt[g] = pin[g].ov_detect && !o_reg.fault;
      assign rdy_evt[g] = o_reg.ready_led && !o_reg.relay_closed;

      a_gate_blocks: assert property (@(posedge aclk) disable iff (!aresetn)
         pin[g].inhibit_or_enable_select && enabled |=> !o_reg.step)
         else $error("step passed while gate energized");
      a_step_edge: assert property (@(posedge aclk) disable iff (!aresetn)
         o_reg.step |-> $past(pin[g].pulse) && !$past(pulse_d_reg) && $past(o_reg.ready_led))
         else $error("step without pulse rising edge");
      // attempts start only from a released edge, the reset edge itself loads zeros
      a_res_decode: assert property (@(posedge aclk) disable iff (!aresetn)
         aresetn |=> o_reg.res == res_fn($past(pin[g].step_sw),
            $past(fine_sw[g] ^ pin[g].micro_in)))
         else $error("resolution decode wrong");
      a_cur_decode: assert property (@(posedge aclk) disable iff (!aresetn)
         aresetn |=> o_reg.cur_deciamp == cur_fn($past(pin[g].phase_current_selector)))
         else $error("current decode wrong");
      a_ired_sense: assert property (@(posedge aclk) disable iff (!aresetn)
         aresetn |=> o_reg.ired_on != $past(pin[g].current_reduction_switch))
         else $error("current reduction sense wrong");
      a_ov_latch: assert property (@(posedge aclk) disable iff (!aresetn)
         pin[g].ov_detect |=> o_reg.fault && o_reg.ov_led && !o_reg.ready_led)
         else $error("overvoltage not flagged");
      a_enable_drop: assert property (@(posedge aclk) disable iff (!aresetn)
         clear_fault && !pin[g].ov_detect |=> !o_reg.fault && !o_reg.ready_led ##1
         o_reg.phase == 3'h0 && !o_reg.relay_closed)
         else $error("enable drop did not clear axis");
      a_ready_delay: assert property (@(posedge aclk) disable iff (!aresetn)
         $rose(o_reg.ready_led) && !o_reg.gate_mode |-> $past(en_cnt_reg) >= READY_CYCLES)
         else $error("ready before enable delay");
      a_ready_reset: assert property (@(posedge aclk)
         !aresetn |=> !o_reg.ready_led && !o_reg.relay_closed)
         else $error("ready high in reset");
   end

   // interrupts: sticky, write one to clear, a new event wins
   logic aw_hold_reg, w_hold_reg, wr_go, rd_go;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic [7:0] wa;
   logic [31:0] wd;
   logic [3:0] ws;
   assign wa = aw_hold_reg ? aw_addr_reg : s_axi_awaddr;
   assign wd = w_hold_reg ? w_data_reg : s_axi_wdata;
   assign ws = w_hold_reg ? w_strb_reg : s_axi_wstrb;
   assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
   assign s_axi_wready = !w_hold_reg && !s_axi_bvalid;
   assign wr_go = (aw_hold_reg || s_axi_awvalid) && (w_hold_reg || s_axi_wvalid) &&
      !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_go = s_axi_arvalid && s_axi_arready;

   always_comb
   begin
      int_status_next = int_status_reg;
      if (wr_go && wa == INT_STATUS_OFS && ws[0])
         int_status_next = int_status_reg & ~wd[3:0];
      int_status_next = int_status_next | {rdy_evt, ov_evt};
      // irq looks at the mask it will meet, not the one being replaced
      int_mask_next = int_mask_reg;
      if (wr_go && ws[0] && wa == INT_MASK_OFS)
         int_mask_next = wd[3:0];
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready && !wr_go)
         begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready && !wr_go)
         begin
            w_hold_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_go)
         begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wa == CTRL_OFS || wa == INT_STATUS_OFS || wa == INT_MASK_OFS) ?
               RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_en_reg <= CTRL_RESET;
         int_mask_reg <= INT_MASK_RESET;
         int_status_reg <= 4'h0;
         irq <= 1'b0;
      end
      else
      begin
         int_status_reg <= int_status_next;
         irq <= |(int_status_next & int_mask_next);
         if (wr_go && ws[0] && wa == CTRL_OFS)
            ctrl_en_reg <= wd[1:0];
         int_mask_reg <= int_mask_next;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end
      else if (rd_go)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= RESP_OKAY;
         case (s_axi_araddr)
            CTRL_OFS: s_axi_rdata <= {30'h0, ctrl_en_reg};
            STAT_OFS: s_axi_rdata <= {24'h0,
               axis_out[1].ready_led, axis_out[1].fault, axis_out[1].ired_on,
               axis_out[1].gate_mode, axis_out[0].ready_led, axis_out[0].fault,
               axis_out[0].ired_on, axis_out[0].gate_mode};
            SET_A1_OFS: s_axi_rdata <= {6'h00, axis_out[0].res,
               3'h0, axis_out[0].cur_deciamp, axis_out[0].cur_code};
            SET_A2_OFS: s_axi_rdata <= {6'h00, axis_out[1].res,
               3'h0, axis_out[1].cur_deciamp, axis_out[1].cur_code};
            INT_STATUS_OFS: s_axi_rdata <= {28'h0, int_status_reg};
            INT_MASK_OFS: s_axi_rdata <= {28'h0, int_mask_reg};
            default:
            begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   a_irq_follow: assert property (@(posedge aclk) disable iff (!aresetn)
      |(int_status_reg & int_mask_reg) |-> irq)
      else $error("irq low with unmasked status");
endmodule

// *** testbench/sdd_pulse_gen.sv ***
`timescale 1ns/10ps
module sdd_pulse_gen
(
   input wire logic aclk,
   input wire logic go,
   input wire logic [7:0] count,
   output logic pulse,
   output logic busy
);
   logic [7:0] left_reg;
   logic [2:0] ph_reg;

   initial
   begin
      pulse = 1'b0;
      busy = 1'b0;
      ph_reg = 3'h0;
      left_reg = 8'h00;
   end

   // square wave, four cycles high and four low, idle low
   always @(posedge aclk)
   begin
      if (go && !busy)
      begin
         left_reg <= count;
         ph_reg <= 3'h0;
         busy <= 1'b1;
      end
      else if (busy)
      begin
         ph_reg <= ph_reg + 3'h1;
         if (ph_reg == 3'h3)
            pulse <= 1'b1;
         if (ph_reg == 3'h7)
         begin
            pulse <= 1'b0;
            left_reg <= left_reg - 8'h01;
            busy <= (left_reg != 8'h01);
         end
      end
   end
endmodule

// *** testbench/sdd_drive_setup_test.sv ***
`timescale 1ns/10ps
module sdd_drive_setup_test;
   import sdd_pkg::*;
   localparam int RC = 20;
   localparam logic [4:0] CUR [16] = '{5'h06, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0d, 5'h0e,
      5'h0f, 5'h10, 5'h12, 5'h13, 5'h14, 5'h15, 5'h17, 5'h18, 5'h19};
   localparam logic [13:0] BASE [4] = '{RES_1000, RES_200, RES_500, RES_400};
   logic aclk, aresetn, irq, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, go, busy, pw;
   logic [7:0] awaddr, araddr, cnt;
   logic [31:0] wdata, rdata, rd_val;
   logic [3:0] wstrb, micro_dip;
   logic [1:0] bresp, rresp;
   sdd_axis_in_t [1:0] pins, ain;
   sdd_axis_out_t [1:0] ao;
   int n_errors, cmp_count, nstep;

   always_comb
   begin
      ain = pins;
      ain[0].pulse = pw;
   end

   sdd_drive_setup #(.READY_CYCLES(RC)) dut (.aclk(aclk), .aresetn(aresetn), .axis_in(ain),
      .micro_dip(micro_dip), .axis_out(ao), .irq(irq), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   sdd_pulse_gen ctl (.aclk(aclk), .go(go), .count(cnt), .pulse(pw), .busy(busy));

   initial
   begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   always @(posedge aclk)
      if (ao[0].step === 1'b1)
         nstep <= nstep + 1;

   task automatic final_report();
      $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("ERROR at %0t: saw %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic tmo();
      n_errors++;
      $display("ERROR at %0t: wait ran out", $time);
      final_report();
   endtask

   task automatic settle();
      repeat (8) @(posedge aclk);
   endtask

   // one access at a time; each channel released at the edge that takes it
   task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] r);
      int k;
      @(posedge aclk);
      awaddr <= a;
      araddr <= a;
      wdata <= d;
      awvalid <= w;
      wvalid <= w;
      bready <= w;
      arvalid <= !w;
      rready <= !w;
      for (k = 0; k < 50; k++)
      begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
         if (arready)
            arvalid <= 1'b0;
         if ((w && bvalid) || (!w && rvalid))
            break;
      end
      if (k == 50)
         tmo();
      r = w ? bresp : rresp;
      rd_val = rdata;
      bready <= 1'b0;
      rready <= 1'b0;
   endtask

   task automatic wait_rdy(output int k);
      for (k = 0; k < 200 && ao[0].ready_led !== 1'b1; k++)
         @(posedge aclk);
      if (k == 200)
         tmo();
   endtask

   task automatic pulses(input logic [7:0] n);
      int k;
      nstep = 0;
      cnt <= n;
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      @(posedge aclk);
      for (k = 0; k < 200 && busy; k++)
         @(posedge aclk);
      if (k == 200)
         tmo();
      repeat (10) @(posedge aclk);
   endtask

   task automatic t_current();
      for (int p = 0; p < 16; p++)
      begin
         pins[0].phase_current_selector <= p[3:0];
         pins[1].phase_current_selector <= 4'(15 - p);
         settle();
         chk(ao[0].cur_deciamp, CUR[p]);
         chk(ao[1].cur_deciamp, CUR[15 - p]);
         chk(ao[0].cur_code, p);
      end
      $display("current selector test done");
   endtask

   task automatic t_res();
      for (int s = 0; s < 4; s++)
         for (int f = 0; f < 4; f++)
         begin
            pins[0].step_sw <= s[1:0];
            pins[1].step_sw <= s[1:0];
            pins[0].micro_in <= f[1];
            pins[1].micro_in <= f[1];
            pins[0].current_reduction_switch <= s[0];
            micro_dip <= {f[0], !f[0], f[0], f[0]};
            settle();
            chk(ao[0].res, BASE[s] * ((f[0] ^ f[1]) ? 10 : 1));
            chk(ao[1].res, BASE[s] * ((!f[0] ^ f[1]) ? 10 : 1));
            chk(ao[0].ired_on, !s[0]);
         end
      $display("resolution test done");
   endtask

   task automatic t_enable();
      int k;
      logic [1:0] r;
      pins[0].gate_en <= 1'b1;
      @(posedge aclk);
      wait_rdy(k);
      chk(k >= RC && k <= RC + 10, 1'b1);
      chk(ao[1].ready_led, 1'b0);
      @(posedge aclk);
      chk(ao[0].relay_closed, 1'b1);
      axi(1'b1, INT_MASK_OFS, 32'h4, r);
      chk(r, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk(irq, 1'b1);
      axi(1'b1, INT_STATUS_OFS, 32'h4, r);
      repeat (2) @(posedge aclk);
      chk(irq, 1'b0);
      $display("enable test done");
   endtask

   task automatic t_steps();
      pulses(8'h05);
      chk(nstep, 5);
      chk(ao[0].phase, 3'h5);
      pins[0].inhibit_or_enable_select <= 1'b1;
      settle();
      chk(ao[0].gate_mode, 1'b1);
      pulses(8'h03);
      chk(nstep, 0);
      pins[0].gate_en <= 1'b0;
      pins[0].dir <= 1'b1;
      settle();
      chk(ao[0].dir, 1'b1);
      // counting down from 5 by four ends at 1, counting up would end at 3
      pulses(8'h04);
      chk(nstep, 4);
      chk(ao[0].phase, 3'h1);
      pins[0].inhibit_or_enable_select <= 1'b0;
      settle();
      chk({ao[0].ready_led, ao[0].relay_closed, ao[0].ring_rst, ao[0].ov_led,
         ao[0].phase}, 7'h18);
      $display("step test done");
   endtask

   task automatic t_ov();
      int k;
      logic [1:0] r;
      axi(1'b0, CTRL_OFS, 32'h0, r);
      chk(rd_val, 32'h3);
      chk(r, RESP_OKAY);
      axi(1'b0, 8'h20, 32'h0, r);
      chk(r, RESP_SLVERR);
      chk(rd_val, 32'h0);
      axi(1'b1, INT_MASK_OFS, 32'h1, r);
      pins[0].gate_en <= 1'b1;
      @(posedge aclk);
      wait_rdy(k);
      repeat (3) @(posedge aclk);
      chk(irq, 1'b0);
      pins[0].ov_detect <= 1'b1;
      settle();
      chk({ao[0].fault, ao[0].ov_led, ao[0].ready_led, irq}, 4'hd);
      pins[0].ov_detect <= 1'b0;
      axi(1'b0, INT_STATUS_OFS, 32'h0, r);
      chk(rd_val[0], 1'b1);
      chk(ao[0].fault, 1'b1);
      pins[0].gate_en <= 1'b0;
      settle();
      chk(ao[0].fault, 1'b0);
      $display("overvoltage test done");
   endtask

   initial
   begin
      n_errors = 0;
      cmp_count = 0;
      nstep = 0;
      aresetn = 1'b0;
      pins = '0;
      micro_dip = 4'h0;
      go = 1'b0;
      cnt = 8'h00;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wdata, wstrb} = '0;
      wstrb = 4'hf;
      repeat (2) @(posedge aclk);
      chk({ao[0].ready_led, ao[1].ready_led, ao[0].relay_closed, irq}, 4'h0);
      aresetn <= 1'b1;
      t_current();
      t_res();
      t_enable();
      t_steps();
      t_ov();
      final_report();
   end
endmodule
